// ### rtl/tap_scan_defs.vh
/*
 * Constants for the test access port instruction-scan block.
 * Assumes inclusion by bare name from rtl/ design files only.
 */
`ifndef TAP_SCAN_DEFS_VH
`define TAP_SCAN_DEFS_VH

// instruction register width and field positions
`define IR_W            5
`define IR_MSB          4
`define IR_LSB          0

// fixed capture pattern, binary 01 in the two low bits
`define IR_CAPTURE      5'h01

// instruction forced while in test-logic-reset (identification)
`define IR_RESET        5'h00

// tap state vector width (one-hot)
`define TAP_STATE_W     16

// depth of the pin synchroniser, in mclk flip-flops
`define SYNC_STAGES     2

`endif

// ### rtl/link_pin_sync.v
/*
 * Two-flop synchronisers for the test clock, mode select and data-in pins,
 * plus rising and falling edge detection of the test clock.
 * Assumes the test clock is far slower than mclk (several mclk per phase).
 */
`timescale 1ns/1ps
module link_pin_sync (
    input  wire mclk,
    input  wire rst_n,
    input  wire tck,
    input  wire tms,
    input  wire tdi,
    output wire tck_rise,
    output wire tck_fall,
    output wire tms_s,
    output wire tdi_s
);
    reg [2:0] tck_meta;
    reg [1:0] tms_meta;
    reg [1:0] tdi_meta;

    // stage 0 feeds only stage 1; stage 2 is the delayed copy for edges
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tck_meta <= 3'h0;
            tms_meta <= 2'h3;
            tdi_meta <= 2'h3;
        end else begin
            tck_meta <= {tck_meta[1:0], tck};
            tms_meta <= {tms_meta[0], tms};
            tdi_meta <= {tdi_meta[0], tdi};
        end
    end

    assign tck_rise = tck_meta[1] & ~tck_meta[2];
    assign tck_fall = ~tck_meta[1] & tck_meta[2];
    assign tms_s    = tms_meta[1];
    assign tdi_s    = tdi_meta[1];
endmodule

// ### rtl/tap_instruction_scan_path.v
/*
 * Test access port controller with the instruction-register scan path.
 * The external test clock, mode select and data-in pins are sampled by
 * mclk; the external data-register path uses the capture, shift and update
 * strobes and returns its serial bit on dr_tdo.
 */
`timescale 1ns/1ps
`include "tap_scan_defs.vh"

// What this block does
// - in select-IR-scan, no data-register strobe fires, so data registers hold.
// - in select-IR-scan, instruction shift stage and latched output stay unchanged.
// - select-IR-scan plus rising edge with mode select low goes to capture-IR.
// - select-IR-scan plus rising edge with mode select high goes to reset.
// - capture-IR loads the shift stage with a fixed pattern on rising edge.
// - capture-IR with mode select high moves to exit1-IR, skipping shifting.
// - capture-IR with mode select low moves to shift-IR.
// - shift-IR links data-in to data-out, shifting one place per rising edge.
// - during shift-IR the latched instruction and data registers hold.
// - shift-IR with mode select low stays in shift-IR and shifts once.
// - shift-IR with mode select high moves to exit1-IR.
// - instruction register is a shift stage plus five-bit latched output.
// - exit1-IR goes to pause-IR on low, update-IR on high.
// - entering update-IR, falling edge latches shifted code as current instruction.
module tap_instruction_scan_path (
    input  wire                        mclk,
    input  wire                        rst_n,
    input  wire                        tck,
    input  wire                        tms,
    input  wire                        tdi,
    input  wire                        dr_tdo,
    output reg                         tdo,
    output reg                         tdo_oe,
    output reg  [`IR_MSB:`IR_LSB]      instr,
    output reg                         ir_updated,
    output reg                         tap_in_reset,
    output reg                         dr_capture,
    output reg                         dr_shift,
    output reg                         dr_update,
    output reg  [`TAP_STATE_W-1:0]     tap_state
);
    localparam [15:0] ST_RESET      = 16'h0001;
    localparam [15:0] ST_IDLE       = 16'h0002;
    localparam [15:0] ST_SEL_DR     = 16'h0004;
    localparam [15:0] ST_CAP_DR     = 16'h0008;
    localparam [15:0] ST_SHIFT_DR   = 16'h0010;
    localparam [15:0] ST_EXIT1_DR   = 16'h0020;
    localparam [15:0] ST_PAUSE_DR   = 16'h0040;
    localparam [15:0] ST_EXIT2_DR   = 16'h0080;
    localparam [15:0] ST_UPDATE_DR  = 16'h0100;
    localparam [15:0] ST_SEL_IR     = 16'h0200;
    localparam [15:0] ST_CAP_IR     = 16'h0400;
    localparam [15:0] ST_SHIFT_IR   = 16'h0800;
    localparam [15:0] ST_EXIT1_IR   = 16'h1000;
    localparam [15:0] ST_PAUSE_IR   = 16'h2000;
    localparam [15:0] ST_EXIT2_IR   = 16'h4000;
    localparam [15:0] ST_UPDATE_IR  = 16'h8000;

    wire                        tck_rise;
    wire                        tck_fall;
    wire                        tms_s;
    wire                        tdi_s;
    reg  [`TAP_STATE_W-1:0]     next_tap_state;
    reg  [`IR_MSB:`IR_LSB]      ir_shift;
    reg  [`IR_MSB:`IR_LSB]      next_ir_shift;

    // one-hot state decode, shared by every strobe and flag
    function in_state;
        input [`TAP_STATE_W-1:0] state;
        input [`TAP_STATE_W-1:0] code;
        begin
            in_state = (state == code);
        end
    endfunction

    link_pin_sync pin_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .tck      (tck),
        .tms      (tms),
        .tdi      (tdi),
        .tck_rise (tck_rise),
        .tck_fall (tck_fall),
        .tms_s    (tms_s),
        .tdi_s    (tdi_s)
    );

    // state transitions taken on each rising test-clock edge
    always @* begin
        next_tap_state = tap_state;
        case (tap_state)
            ST_RESET: begin
                if (tms_s) begin
                    next_tap_state = ST_RESET;
                end else begin
                    next_tap_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (tms_s) begin
                    next_tap_state = ST_SEL_DR;
                end else begin
                    next_tap_state = ST_IDLE;
                end
            end
            ST_SEL_DR: begin
                if (tms_s) begin
                    next_tap_state = ST_SEL_IR;
                end else begin
                    next_tap_state = ST_CAP_DR;
                end
            end
            ST_CAP_DR: begin
                if (tms_s) begin
                    next_tap_state = ST_EXIT1_DR;
                end else begin
                    next_tap_state = ST_SHIFT_DR;
                end
            end
            ST_SHIFT_DR: begin
                if (tms_s) begin
                    next_tap_state = ST_EXIT1_DR;
                end else begin
                    next_tap_state = ST_SHIFT_DR;
                end
            end
            ST_EXIT1_DR: begin
                if (tms_s) begin
                    next_tap_state = ST_UPDATE_DR;
                end else begin
                    next_tap_state = ST_PAUSE_DR;
                end
            end
            ST_PAUSE_DR: begin
                if (tms_s) begin
                    next_tap_state = ST_EXIT2_DR;
                end else begin
                    next_tap_state = ST_PAUSE_DR;
                end
            end
            ST_EXIT2_DR: begin
                if (tms_s) begin
                    next_tap_state = ST_UPDATE_DR;
                end else begin
                    next_tap_state = ST_SHIFT_DR;
                end
            end
            ST_UPDATE_DR: begin
                if (tms_s) begin
                    next_tap_state = ST_SEL_DR;
                end else begin
                    next_tap_state = ST_IDLE;
                end
            end
            ST_SEL_IR: begin
                if (tms_s) begin
                    next_tap_state = ST_RESET;
                end else begin
                    next_tap_state = ST_CAP_IR;
                end
            end
            ST_CAP_IR: begin
                if (tms_s) begin
                    next_tap_state = ST_EXIT1_IR;
                end else begin
                    next_tap_state = ST_SHIFT_IR;
                end
            end
            ST_SHIFT_IR: begin
                if (tms_s) begin
                    next_tap_state = ST_EXIT1_IR;
                end else begin
                    next_tap_state = ST_SHIFT_IR;
                end
            end
            ST_EXIT1_IR: begin
                if (tms_s) begin
                    next_tap_state = ST_UPDATE_IR;
                end else begin
                    next_tap_state = ST_PAUSE_IR;
                end
            end
            ST_PAUSE_IR: begin
                if (tms_s) begin
                    next_tap_state = ST_EXIT2_IR;
                end else begin
                    next_tap_state = ST_PAUSE_IR;
                end
            end
            ST_EXIT2_IR: begin
                if (tms_s) begin
                    next_tap_state = ST_UPDATE_IR;
                end else begin
                    next_tap_state = ST_SHIFT_IR;
                end
            end
            ST_UPDATE_IR: begin
                if (tms_s) begin
                    next_tap_state = ST_SEL_DR;
                end else begin
                    next_tap_state = ST_IDLE;
                end
            end
            default: begin
                next_tap_state = ST_RESET;
            end
        endcase
    end

    // instruction shift stage: only capture-IR and shift-IR change it
    always @* begin
        next_ir_shift = ir_shift;
        case (tap_state)
            ST_CAP_IR: begin
                next_ir_shift = `IR_CAPTURE;
            end
            ST_SHIFT_IR: begin
                next_ir_shift = {tdi_s, ir_shift[`IR_MSB:`IR_LSB+1]};
            end
            default: begin
                next_ir_shift = ir_shift;
            end
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tap_state <= ST_RESET;
        end else if (tck_rise) begin
            tap_state <= next_tap_state;
        end
    end

    // shift stage is a separate register from the latched output
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ir_shift <= `IR_CAPTURE;
        end else if (tck_rise) begin
            ir_shift <= next_ir_shift;
        end
    end

    // latched instruction: only update-IR or reset changes it
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            instr      <= `IR_RESET;
            ir_updated <= 1'b0;
        end else begin
            ir_updated <= 1'b0;
            if (in_state(tap_state, ST_RESET)) begin
                instr <= `IR_RESET;
            end else if (tck_fall && in_state(tap_state, ST_UPDATE_IR)) begin
                instr      <= ir_shift;
                ir_updated <= 1'b1;
            end else begin
                instr <= instr;
            end
        end
    end

    // data-register strobes fire only in data-register states
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dr_capture <= 1'b0;
            dr_shift   <= 1'b0;
            dr_update  <= 1'b0;
        end else begin
            dr_capture <= tck_rise && in_state(tap_state, ST_CAP_DR);
            dr_shift   <= tck_rise && in_state(tap_state, ST_SHIFT_DR);
            dr_update  <= tck_fall && in_state(tap_state, ST_UPDATE_DR);
        end
    end

    // serial output changes on the falling test-clock edge
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            case (tap_state)
                ST_SHIFT_IR: begin
                    tdo    <= ir_shift[`IR_LSB];
                    tdo_oe <= 1'b1;
                end
                ST_SHIFT_DR: begin
                    tdo    <= dr_tdo;
                    tdo_oe <= 1'b1;
                end
                default: begin
                    tdo    <= 1'b0;
                    tdo_oe <= 1'b0;
                end
            endcase
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tap_in_reset <= 1'b1;
        end else begin
            tap_in_reset <= in_state(tap_state, ST_RESET);
        end
    end
endmodule

// ### test/tap_scan_monitor.sv
/* port checker for the instruction scan path.
   assumes bind onto tap_instruction_scan_path, all in the mclk domain. */
`timescale 1ns/1ps
module tap_scan_monitor (
    input wire        mclk,
    input wire        rst_n,
    input wire        tdo,
    input wire        tdo_oe,
    input wire [4:0]  instr,
    input wire        ir_updated,
    input wire        dr_capture,
    input wire        dr_shift,
    input wire        dr_update,
    input wire [15:0] tap_state
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire dr_any = dr_capture | dr_shift | dr_update;
    sel_hold_a: assert property (
        tap_state[9] |=> $stable(instr) && !dr_any) else $error("select-ir changed a register");
    sel_next_a: assert property (
        $fell(tap_state[9]) |-> tap_state[10] || tap_state[0]) else $error("bad select-ir exit");
    cap_next_a: assert property (
        $fell(tap_state[10]) |-> tap_state[11] || tap_state[12]) else $error("bad capture exit");
    shift_next_a: assert property (
        $fell(tap_state[11]) |-> tap_state[12]) else $error("bad shift-ir exit");
    exit_next_a: assert property (
        $fell(tap_state[12]) |-> tap_state[13] || tap_state[15]) else $error("bad exit1 exit");
    shift_hold_a: assert property (
        tap_state[11] |=> $stable(instr) && !dr_any) else $error("shift-ir changed a register");
    instr_src_a: assert property (
        $changed(instr) |-> tap_state[15] || tap_state[0] || $past(tap_state[0]))
        else $error("instruction changed outside update");
    upd_pulse_a: assert property (
        ir_updated |-> tap_state[15] ##1 !ir_updated) else $error("bad update pulse");
    oe_rise_a: assert property (
        $rose(tdo_oe) |-> tap_state[11] || tap_state[4]) else $error("output on outside shift");
    oe_off_a: assert property (
        !tdo_oe |-> !tdo) else $error("released output not low");
    cover property (tap_state[10] ##1 tap_state[12]);
    cover property (ir_updated);
    cover property ($fell(tap_state[9]) && tap_state[0]);
endmodule
bind tap_instruction_scan_path tap_scan_monitor u_mon (.mclk, .rst_n, .tdo, .tdo_oe, .instr,
    .ir_updated, .dr_capture, .dr_shift, .dr_update, .tap_state);

// ### test/jtag_host_model.sv
/* test controller model driving the link pins.
   assumes a free running mclk; test clock stands low between steps. */
`timescale 1ns/1ps
module jtag_host_model (
    input  wire  mclk,
    input  wire  tdo,
    input  wire  tdo_oe,
    output logic tck,
    output logic tms,
    output logic tdi
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 80 ns period; o is {oe, data} seen just before the rise
    task automatic step(input logic m, input logic d, output logic [1:0] o);
        tms = m;
        tdi = d;
        repeat (5) @(posedge mclk);
        #1;
        o = {tdo_oe, tdo};
        tck = 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        tck = 1'b0;
    endtask
    task automatic shift_ir(input int n, input logic [15:0] din, output logic [15:0] dout,
                            output logic oe_ok);
        logic [1:0] o;
        oe_ok = 1'b1;
        dout = 16'h0000;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o[0];
            oe_ok = oe_ok & o[1];
        end
    endtask
endmodule

// ### test/testbench.sv
/* self-checking bench for the instruction scan path.
   assumes the design and the host model compile before it. */
`timescale 1ns/1ps
module testbench;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        dr_tdo = 1'b0;
    wire         tck, tms, tdi, tdo, tdo_oe, ir_updated, tap_in_reset;
    wire         dr_capture, dr_shift, dr_update;
    wire  [4:0]  instr;
    wire  [15:0] tap_state;
    int          fails = 0;
    int          total_checks = 0;
    logic [1:0]  o;
    logic [15:0] dout;
    logic        oe_ok;
    int          n_cap = 0;
    int          n_dsh = 0;
    int          n_dup = 0;
    int          n_upd = 0;
    always #4 mclk = ~mclk;
    always @(posedge mclk) #1 dr_tdo = ~dr_tdo;
    // pulse counters for the data-register strobes and the update flag
    always @(posedge mclk) begin
        n_cap += dr_capture;
        n_dsh += dr_shift;
        n_dup += dr_update;
        n_upd += ir_updated;
    end
    tap_instruction_scan_path DUT (.mclk, .rst_n, .tck, .tms, .tdi, .dr_tdo, .tdo, .tdo_oe,
        .instr, .ir_updated, .tap_in_reset, .dr_capture, .dr_shift, .dr_update, .tap_state);
    jtag_host_model host (.mclk, .tdo, .tdo_oe, .tck, .tms, .tdi);
    task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task to_sel_ir;
        host.step(1, 0, o);
        host.step(1, 0, o);
        chk("sel state", tap_state, 16'h0200);
    endtask
    task automatic t_load(input logic [4:0] code, input logic [4:0] pre);
        logic [4:0] old;
        int         dr0;
        int         up0;
        old = instr;
        dr0 = n_cap + n_dsh + n_dup;
        up0 = n_upd;
        to_sel_ir();
        chk("sel instr", instr, old);
        host.step(0, 0, o);
        chk("cap state", tap_state, 16'h0400);
        host.step(0, 0, o);
        chk("shift state", tap_state, 16'h0800);
        host.shift_ir(10, {6'h00, code, pre}, dout, oe_ok);
        chk("ir out", dout[9:0], {pre, 5'h01});
        chk("oe shift", oe_ok, 1'b1);
        chk("instr shift", instr, old);
        chk("exit1 state", tap_state, 16'h1000);
        host.step(1, 0, o);
        chk("oe released", o, 2'b00);
        chk("upd state", tap_state, 16'h8000);
        host.step(0, 0, o);
        chk("instr new", instr, code);
        chk("idle state", tap_state, 16'h0002);
        chk("dr strobes", n_cap + n_dsh + n_dup - dr0, 16'h0000);
        chk("upd pulses", n_upd - up0, 16'h0001);
        $display("test load %h done", code);
    endtask
    task t_skip;
        to_sel_ir();
        host.step(0, 1, o);
        host.step(1, 1, o);
        chk("skip exit1", tap_state, 16'h1000);
        host.step(0, 1, o);
        chk("pause state", tap_state, 16'h2000);
        host.step(1, 1, o);
        host.step(1, 1, o);
        host.step(0, 1, o);
        chk("capture code", instr, 5'h01);
        $display("test skip done");
    endtask
    task automatic t_dr;
        int c0;
        int s0;
        int u0;
        c0 = n_cap;
        s0 = n_dsh;
        u0 = n_dup;
        host.step(1, 0, o);
        host.step(0, 0, o);
        host.step(0, 0, o);
        chk("dr capture", n_cap - c0, 16'h0001);
        host.step(1, 0, o);
        chk("dr oe", o[1], 1'b1);
        chk("dr shift", n_dsh - s0, 16'h0001);
        host.step(1, 0, o);
        chk("dr oe off", o[1], 1'b0);
        host.step(0, 0, o);
        chk("dr update", n_dup - u0, 16'h0001);
        chk("dr instr", instr, 5'h01);
        $display("test data path done");
    endtask
    task t_sel_rst;
        to_sel_ir();
        host.step(1, 0, o);
        chk("reset state", tap_state, 16'h0001);
        chk("reset instr", instr, 5'h00);
        chk("in reset", tap_in_reset, 1'b1);
        host.step(0, 0, o);
        $display("test select reset done");
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        chk("rst state", tap_state, 16'h0001);
        chk("rst oe", tdo_oe, 1'b0);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        host.step(0, 0, o);
        chk("idle state", tap_state, 16'h0002);
        t_load(5'h1f, 5'h0a);
        t_load(5'h03, 5'h15);
        t_skip();
        t_dr();
        t_sel_rst();
        results();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        results();
    end
endmodule
